// [rtl/ucg_pkg.sv]
/*
  Package of the serial clock generator: register offsets, field positions, reset values,
  divider limits and the clock-mode enumeration.
  Assumes an 8-bit register port with a 3-bit word address.
*/
package ucg_pkg;

  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned DIV_W  = 12;
  localparam int unsigned HIGH_W = 4;
  localparam int unsigned PH_W   = 4;

  ////////////////////////////////////////////////////////////////////////////////////////
  // Register offsets.
  localparam logic [2:0] OFS_CTRL_STATUS_A   = 3'h0;
  localparam logic [2:0] OFS_CTRL_STATUS_C   = 3'h1;
  localparam logic [2:0] OFS_BAUD_HIGH       = 3'h2;
  localparam logic [2:0] OFS_BAUD_LOW        = 3'h3;
  localparam logic [2:0] OFS_XFER_DIR        = 3'h4;
  localparam logic [2:0] OFS_POWER_REDUCTION = 3'h5;
  localparam logic [2:0] OFS_CLK_STATUS      = 3'h6;

  ////////////////////////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int unsigned BIT_DOUBLE_SPEED = 1;
  localparam int unsigned BIT_SYNC_MODE    = 6;
  localparam int unsigned BIT_SYNC_POL     = 0;
  localparam int unsigned BIT_XFER_DIR     = 0;
  localparam int unsigned BIT_POWER_CUT    = 0;
  localparam int unsigned BIT_STAT_MODE_LO = 0;
  localparam int unsigned BIT_STAT_XCK     = 2;

  ////////////////////////////////////////////////////////////////////////////////////////
  // Reset values.
  localparam logic              RST_BIT     = 1'b0;
  localparam logic [HIGH_W-1:0] RST_HIGH    = 4'h0;
  localparam logic [DIV_W-1:0]  RST_DIVISOR = 12'h000;
  localparam logic [PH_W-1:0]   RST_PHASE   = 4'h0;
  localparam logic [DATA_W-1:0] RST_DATA    = 8'h00;

  ////////////////////////////////////////////////////////////////////////////////////////
  // Last state of the recovery counter: 16, 8 and 2 states.
  localparam logic [PH_W-1:0] LAST_NORMAL = 4'hf;
  localparam logic [PH_W-1:0] LAST_DOUBLE = 4'h7;
  localparam logic [PH_W-1:0] LAST_MASTER = 4'h1;

  typedef enum logic [1:0] {
    UCG_ASYNC_NORMAL = 2'b00,
    UCG_ASYNC_DOUBLE = 2'b01,
    UCG_SYNC_MASTER  = 2'b10,
    UCG_SYNC_SLAVE   = 2'b11
  } ucg_mode_t;

endpackage : ucg_pkg

// [rtl/ucg_baud_counter.sv]
/*
  Reloadable 12-bit baud down-counter with a one-cycle tick at each zero.
  Assumes load, load_value, divisor and enable come from logic on core_clk.
*/
`timescale 1ns/1ps

module ucg_baud_counter (
  input  wire logic                        core_clk,
  input  wire logic                        rst_b,
  input  wire logic                        enable,
  input  wire logic                        load,
  input  wire logic [ucg_pkg::DIV_W-1:0]   load_value,
  input  wire logic [ucg_pkg::DIV_W-1:0]   divisor,
  output logic                             tick
);

  typedef struct packed {
    logic [ucg_pkg::DIV_W-1:0] cnt;
    logic                      tick;
  } ucg_cnt_state_t;

  ucg_cnt_state_t q;
  ucg_cnt_state_t next_q;

  ////////////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_q      = q;
    next_q.tick = 1'b0;
    if (load) begin
      next_q.cnt = load_value;
    end else if (enable) begin
      if (q.cnt == ucg_pkg::RST_DIVISOR) begin
        next_q.cnt  = divisor;
        next_q.tick = 1'b1;
      end else begin
        next_q.cnt = q.cnt - 12'h001;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign tick = q.tick;

  ////////////////////////////////////////////////////////////////////////////////////////
  AST_LOAD_VALUE: assert property (@(posedge core_clk) disable iff (!rst_b)
    load |=> (q.cnt == $past(load_value)))
    else $error("Counter did not take the loaded divisor.");

  AST_ZERO_TICK: assert property (@(posedge core_clk) disable iff (!rst_b)
    (enable && !load && q.cnt == 12'h000) |=> (tick && q.cnt == $past(divisor)))
    else $error("Zero count gave no tick or no reload.");

  AST_DECREMENT: assert property (@(posedge core_clk) disable iff (!rst_b)
    (enable && !load && q.cnt != 12'h000) |=> (!tick && q.cnt == $past(q.cnt) - 12'h001))
    else $error("Counter did not step down by one.");

endmodule : ucg_baud_counter

// [rtl/ucg_clock_gen.sv]
/*
  Clock generator of the serial unit: register port, baud generator, transmit divider,
  receive recovery state count and transfer-clock pin handling for all four modes.
  Assumes a register master on core_clk and a transfer-clock pin from outside the domain.
*/
// Functional notes
// - Four clock modes: async normal, async double, sync master, sync slave.
// - Sync mode bit set selects synchronous, cleared selects asynchronous operation.
// - In sync mode pin direction output means master, input means slave.
// - Transfer-clock pin is used only in synchronous modes.
// - Master drives its own clock on the pin; slave takes clock from pin.
// - Down-counter steps each cycle, reloads at zero and on low-byte write.
// - One baud tick per zero, rate is clock over divisor plus one.
// - Transmit clock is baud divided by 16, 8 or 2 per mode.
// - Receiver takes undivided baud ticks, with 16, 8 or 2 states.
// - Divisor is twelve bits, high part plus low byte.
// - Double-speed bit acts only in asynchronous mode, making 16 into 8.
// - With double speed the receiver uses 8 samples per bit.
// - Slave clock input is synchronised then edge detected before use.
// - Synchronising adds two cycles; the far clock stays below a quarter rate.
// - Polarity clear: change on rising, sample on falling; set reverses.
`timescale 1ns/1ps

module ucg_clock_gen (
  input  wire logic                          core_clk,
  input  wire logic                          rst_b,
  input  wire logic [ucg_pkg::ADDR_W-1:0]    reg_addr,
  input  wire logic [ucg_pkg::DATA_W-1:0]    reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [ucg_pkg::DATA_W-1:0]    reg_rdata,
  input  wire logic                          xck_in,
  output logic                               xck_out,
  output logic                               xck_oe,
  output logic                               txclk,
  output logic                               rxclk,
  output logic      [ucg_pkg::PH_W-1:0]      rx_phase,
  output logic                               tx_change,
  output logic                               rx_sample
);

  typedef struct packed {
    logic                        double_speed_bit;
    logic                        sync_mode_select;
    logic                        sync_clock_polarity;
    logic [ucg_pkg::HIGH_W-1:0]  baud_divisor_high;
    logic [ucg_pkg::DIV_W-1:0]   baud_divisor;
    logic                        xfer_clk_direction;
    logic                        serial0_power_cut;
    ucg_pkg::ucg_mode_t          mode;
    logic [ucg_pkg::PH_W-1:0]    rx_phase;
    logic                        xck_s1;
    logic                        xck_s2;
    logic                        xck_s3;
    logic                        xck_out;
    logic                        xck_oe;
    logic                        txclk;
    logic                        rxclk;
    logic                        tx_change;
    logic                        rx_sample;
    logic [ucg_pkg::DATA_W-1:0]  rd_data;
  } ucg_state_t;

  ucg_state_t                q;
  ucg_state_t                next_q;
  logic                      baud_tick;
  logic                      low_write;
  logic [ucg_pkg::DIV_W-1:0] low_value;
  logic                      baud_enable;
  logic                      xck_rise;
  logic                      xck_fall;
  logic [ucg_pkg::PH_W-1:0]  phase_last;

  ////////////////////////////////////////////////////////////////////////////////////////
  // Baud generator. It stops in slave mode and under power cut, as only internal modes use it.
  assign low_write   = reg_wr && (reg_addr == ucg_pkg::OFS_BAUD_LOW);
  assign low_value   = {q.baud_divisor_high, reg_wdata};
  assign baud_enable = !q.serial0_power_cut && (q.mode != ucg_pkg::UCG_SYNC_SLAVE);

  ucg_baud_counter u_baud (
    .core_clk   (core_clk),
    .rst_b      (rst_b),
    .enable     (baud_enable),
    .load       (low_write),
    .load_value (low_value),
    .divisor    (q.baud_divisor),
    .tick       (baud_tick)
  );

  ////////////////////////////////////////////////////////////////////////////////////////
  // Edge detection looks only at the second and third stages, never at the first.
  assign xck_rise = q.xck_s2 && !q.xck_s3;
  assign xck_fall = !q.xck_s2 && q.xck_s3;

  always_comb begin
    unique case (q.mode)
      ucg_pkg::UCG_ASYNC_NORMAL: phase_last = ucg_pkg::LAST_NORMAL;
      ucg_pkg::UCG_ASYNC_DOUBLE: phase_last = ucg_pkg::LAST_DOUBLE;
      ucg_pkg::UCG_SYNC_MASTER:  phase_last = ucg_pkg::LAST_MASTER;
      ucg_pkg::UCG_SYNC_SLAVE:   phase_last = ucg_pkg::LAST_MASTER;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_q           = q;
    next_q.txclk     = 1'b0;
    next_q.rxclk     = 1'b0;
    next_q.tx_change = 1'b0;
    next_q.rx_sample = 1'b0;
    next_q.rd_data   = ucg_pkg::RST_DATA;

    if (reg_wr) begin
      unique case (reg_addr)
        ucg_pkg::OFS_CTRL_STATUS_A: begin
          next_q.double_speed_bit = reg_wdata[ucg_pkg::BIT_DOUBLE_SPEED];
        end
        ucg_pkg::OFS_CTRL_STATUS_C: begin
          next_q.sync_mode_select    = reg_wdata[ucg_pkg::BIT_SYNC_MODE];
          next_q.sync_clock_polarity = reg_wdata[ucg_pkg::BIT_SYNC_POL];
        end
        ucg_pkg::OFS_BAUD_HIGH: begin
          next_q.baud_divisor_high = reg_wdata[ucg_pkg::HIGH_W-1:0];
        end
        ucg_pkg::OFS_BAUD_LOW: begin
          next_q.baud_divisor = low_value;
        end
        ucg_pkg::OFS_XFER_DIR: begin
          next_q.xfer_clk_direction = reg_wdata[ucg_pkg::BIT_XFER_DIR];
        end
        ucg_pkg::OFS_POWER_REDUCTION: begin
          next_q.serial0_power_cut = reg_wdata[ucg_pkg::BIT_POWER_CUT];
        end
        default: begin
        end
      endcase
    end

    if (reg_rd) begin
      unique case (reg_addr)
        ucg_pkg::OFS_CTRL_STATUS_A: begin
          next_q.rd_data[ucg_pkg::BIT_DOUBLE_SPEED] = q.double_speed_bit;
        end
        ucg_pkg::OFS_CTRL_STATUS_C: begin
          next_q.rd_data[ucg_pkg::BIT_SYNC_MODE] = q.sync_mode_select;
          next_q.rd_data[ucg_pkg::BIT_SYNC_POL]  = q.sync_clock_polarity;
        end
        ucg_pkg::OFS_BAUD_HIGH: begin
          next_q.rd_data[ucg_pkg::HIGH_W-1:0] = q.baud_divisor_high;
        end
        ucg_pkg::OFS_BAUD_LOW: begin
          next_q.rd_data = q.baud_divisor[ucg_pkg::DATA_W-1:0];
        end
        ucg_pkg::OFS_XFER_DIR: begin
          next_q.rd_data[ucg_pkg::BIT_XFER_DIR] = q.xfer_clk_direction;
        end
        ucg_pkg::OFS_POWER_REDUCTION: begin
          next_q.rd_data[ucg_pkg::BIT_POWER_CUT] = q.serial0_power_cut;
        end
        ucg_pkg::OFS_CLK_STATUS: begin
          next_q.rd_data[ucg_pkg::BIT_STAT_MODE_LO+1:ucg_pkg::BIT_STAT_MODE_LO] = q.mode;
          next_q.rd_data[ucg_pkg::BIT_STAT_XCK] = q.xck_s2;
        end
        default: begin
        end
      endcase
    end

    // Mode decode. Double speed is ignored while synchronous mode is selected.
    if (!next_q.sync_mode_select) begin
      next_q.mode = next_q.double_speed_bit ? ucg_pkg::UCG_ASYNC_DOUBLE : ucg_pkg::UCG_ASYNC_NORMAL;
    end else begin
      next_q.mode = next_q.xfer_clk_direction ? ucg_pkg::UCG_SYNC_MASTER : ucg_pkg::UCG_SYNC_SLAVE;
    end

    // Pin synchroniser: the first stage feeds only the second.
    next_q.xck_s1 = xck_in;
    next_q.xck_s2 = q.xck_s1;
    next_q.xck_s3 = q.xck_s2;

    // A mode change restarts the dividers, so a stale phase never exceeds the new state count.
    if ((next_q.mode != q.mode) || q.serial0_power_cut) begin
      next_q.rx_phase = ucg_pkg::RST_PHASE;
      next_q.xck_out  = 1'b0;
    end else begin
      unique case (q.mode)
        ucg_pkg::UCG_ASYNC_NORMAL, ucg_pkg::UCG_ASYNC_DOUBLE: begin
          if (baud_tick) begin
            next_q.rxclk = 1'b1;
            if (q.rx_phase == phase_last) begin
              next_q.rx_phase = ucg_pkg::RST_PHASE;
              next_q.txclk    = 1'b1;
            end else begin
              next_q.rx_phase = q.rx_phase + 4'h1;
            end
          end
          next_q.xck_out = 1'b0;
        end
        ucg_pkg::UCG_SYNC_MASTER: begin
          if (baud_tick) begin
            next_q.rxclk    = 1'b1;
            next_q.xck_out  = !q.xck_out;
            next_q.rx_phase = (q.rx_phase == phase_last) ? ucg_pkg::RST_PHASE : q.rx_phase + 4'h1;
            next_q.txclk    = (q.rx_phase == phase_last);
            if (next_q.xck_out ^ q.sync_clock_polarity) begin
              next_q.tx_change = 1'b1;
            end else begin
              next_q.rx_sample = 1'b1;
            end
          end
        end
        ucg_pkg::UCG_SYNC_SLAVE: begin
          next_q.xck_out   = 1'b0;
          next_q.tx_change = q.sync_clock_polarity ? xck_fall : xck_rise;
          next_q.rx_sample = q.sync_clock_polarity ? xck_rise : xck_fall;
          next_q.txclk     = next_q.tx_change;
          next_q.rxclk     = next_q.rx_sample;
        end
      endcase
    end

    next_q.xck_oe = (next_q.mode == ucg_pkg::UCG_SYNC_MASTER) && !next_q.serial0_power_cut;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  assign reg_rdata = q.rd_data;
  assign xck_out   = q.xck_out;
  assign xck_oe    = q.xck_oe;
  assign txclk     = q.txclk;
  assign rxclk     = q.rxclk;
  assign rx_phase  = q.rx_phase;
  assign tx_change = q.tx_change;
  assign rx_sample = q.rx_sample;

  ////////////////////////////////////////////////////////////////////////////////////////
  AST_SYNC_SELECT: assert property (@(posedge core_clk) disable iff (!rst_b)
    (reg_wr && reg_addr == ucg_pkg::OFS_CTRL_STATUS_C) |=> (q.mode[1] == $past(reg_wdata[ucg_pkg::BIT_SYNC_MODE])))
    else $error("Sync mode bit did not select the clock family.");

  AST_PIN_ASYNC_IDLE: assert property (@(posedge core_clk) disable iff (!rst_b)
    !q.sync_mode_select |-> (!xck_oe && !xck_out && !tx_change && !rx_sample))
    else $error("Transfer clock pin active in asynchronous mode.");

  AST_DIR_SELECT: assert property (@(posedge core_clk) disable iff (!rst_b)
    (q.sync_mode_select && !q.serial0_power_cut) |-> (xck_oe == q.xfer_clk_direction))
    else $error("Pin direction did not pick master or slave.");

  AST_MASTER_TOGGLE: assert property (@(posedge core_clk) disable iff (!rst_b)
    (q.mode == ucg_pkg::UCG_SYNC_MASTER && next_q.mode == q.mode && !q.serial0_power_cut && baud_tick)
      |=> (xck_out != $past(xck_out)))
    else $error("Master clock did not toggle on a baud tick.");

  AST_TX_DIV16: assert property (@(posedge core_clk) disable iff (!rst_b)
    (q.mode == ucg_pkg::UCG_ASYNC_NORMAL && next_q.mode == q.mode && !q.serial0_power_cut && baud_tick)
      |=> (txclk == ($past(q.rx_phase) == ucg_pkg::LAST_NORMAL)))
    else $error("Normal mode transmit clock not baud over 16.");

  AST_RX_STATES_MASTER: assert property (@(posedge core_clk) disable iff (!rst_b)
    (q.mode == ucg_pkg::UCG_SYNC_MASTER) |-> (rx_phase <= ucg_pkg::LAST_MASTER))
    else $error("Master mode recovery counter exceeds two states.");

  AST_RX_STATES_DOUBLE: assert property (@(posedge core_clk) disable iff (!rst_b)
    (q.mode == ucg_pkg::UCG_ASYNC_DOUBLE) |-> (rx_phase <= ucg_pkg::LAST_DOUBLE))
    else $error("Double speed recovery counter exceeds eight states.");

  AST_DOUBLE_IGNORED_SYNC: assert property (@(posedge core_clk) disable iff (!rst_b)
    (q.sync_mode_select && q.double_speed_bit) |-> (q.mode != ucg_pkg::UCG_ASYNC_DOUBLE))
    else $error("Double speed took effect in synchronous mode.");

  AST_HIGH_HELD: assert property (@(posedge core_clk) disable iff (!rst_b)
    (reg_wr && reg_addr == ucg_pkg::OFS_BAUD_HIGH) |=> (q.baud_divisor == $past(q.baud_divisor)))
    else $error("High part write changed the active divisor.");

  AST_SLAVE_EDGE_DELAY: assert property (@(posedge core_clk) disable iff (!rst_b)
    (q.mode == ucg_pkg::UCG_SYNC_SLAVE && next_q.mode == q.mode && !q.serial0_power_cut && !q.sync_clock_polarity
      && q.xck_s1 && !q.xck_s2) |=> ##1 tx_change)
    else $error("Slave rising edge not seen two cycles after capture.");

  AST_MASTER_POLARITY: assert property (@(posedge core_clk) disable iff (!rst_b)
    (q.mode == ucg_pkg::UCG_SYNC_MASTER && $rose(xck_out)) |-> (tx_change == !q.sync_clock_polarity))
    else $error("Master data change edge does not follow polarity.");

endmodule : ucg_clock_gen

// [tb/ucg_far_end.sv]
/*
  Far-side serial transceiver model: it shares the transfer-clock pin with the clock generator.
  Assumes one core clock. The far clock stands still and low outside frames.
*/
`timescale 1ns/1ps

module ucg_far_end #(
  parameter int HALF = 4
) (
  input  wire logic core_clk,
  input  wire logic run,
  input  wire logic xck_oe,
  input  wire logic xck_out,
  output logic      pin,
  output int        n_rise,
  output int        n_fall
);
  logic far_lvl;
  logic pin_q;

  ////////////////////////////////////////////////////////////////////////////////////////
  // Each half lasts HALF core cycles, so the far clock stays under a quarter of the core rate.
  initial begin
    far_lvl = 1'b0;
    forever begin
      @(posedge core_clk);
      if (run) begin
        far_lvl <= 1'b1;
        repeat (HALF) @(posedge core_clk);
        far_lvl <= 1'b0;
        repeat (HALF - 1) @(posedge core_clk);
      end
    end
  end

  // The master drives the pin while its enable is high; otherwise this side drives it.
  assign pin = xck_oe ? xck_out : far_lvl;

  always @(posedge core_clk) begin
    pin_q <= pin;
    if (pin === 1'b1 && pin_q === 1'b0) n_rise <= n_rise + 1;
    if (pin === 1'b0 && pin_q === 1'b1) n_fall <= n_fall + 1;
  end
endmodule : ucg_far_end

// [tb/usart_clock_generator_test.sv]
/*
  Self-checking testbench of the serial clock generator: register tasks, period measurement.
  Assumes the far-end model in its own file and the design package compiled first.
*/
`timescale 1ns/1ps

module usart_clock_generator_test;
  logic       core_clk;
  logic       rst_b;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       xck_in;
  logic       xck_out;
  logic       xck_oe;
  logic       txclk;
  logic       rxclk;
  logic [3:0] rx_phase;
  logic       tx_change;
  logic       rx_sample;
  logic       run;
  int         n_rise;
  int         n_fall;
  int         n_errors;
  int         n_tests;
  int         n_tx;
  int         n_rx;

  ucg_clock_gen uut (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .xck_in(xck_in), .xck_out(xck_out),
    .xck_oe(xck_oe), .txclk(txclk), .rxclk(rxclk), .rx_phase(rx_phase), .tx_change(tx_change),
    .rx_sample(rx_sample));

  ucg_far_end #(.HALF(4)) far (.core_clk(core_clk), .run(run), .xck_oe(xck_oe), .xck_out(xck_out),
    .pin(xck_in), .n_rise(n_rise), .n_fall(n_fall));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    if (tx_change === 1'b1) n_tx <= n_tx + 1;
    if (rx_sample === 1'b1) n_rx <= n_rx + 1;
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so they are taken at that cycle's falling edge.
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    v = reg_rdata;
  endtask : rd

  function automatic logic pick(input int s);
    case (s)
      0:       return rxclk;
      1:       return txclk;
      2:       return tx_change;
      default: return rx_sample;
    endcase
  endfunction : pick

  // The first interval after a reconfiguration may be partial, so only the second one counts.
  task automatic period(input int s, output int p);
    for (int k = 0; k < 2; k++) begin
      p = 0;
      while (pick(s) !== 1'b1 && p < 9000) begin
        @(negedge core_clk);
        p++;
      end
      p = 0;
      do begin
        @(negedge core_clk);
        p++;
      end while (pick(s) !== 1'b1 && p < 9000);
    end
  endtask : period

  task automatic conclude();
    if (n_errors == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude

  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    conclude();
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] v;
    logic [3:0] mx;
    int         p;
    int         c;
    int         t0;
    int         r0;
    int         f0;
    rst_b = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    run = 1'b0;
    n_errors = 0;
    n_tests = 0;
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      rd(a[2:0], v);
      chk("reset value", v, 8'h00);
    end
    wr(3'h7, 8'hff);
    rd(3'h7, v);
    chk("unmapped read", v, 8'h00);
    wr(ucg_pkg::OFS_CLK_STATUS, 8'hff);
    rd(ucg_pkg::OFS_CLK_STATUS, v);
    chk("status after write", v, 8'h00);
    wr(ucg_pkg::OFS_CTRL_STATUS_A, 8'hff);
    rd(ucg_pkg::OFS_CTRL_STATUS_A, v);
    chk("ctrl_status_a", v, 8'h02);
    wr(ucg_pkg::OFS_CTRL_STATUS_C, 8'hff);
    rd(ucg_pkg::OFS_CTRL_STATUS_C, v);
    chk("ctrl_status_c", v, 8'h41);
    wr(ucg_pkg::OFS_CTRL_STATUS_A, 8'h00);
    wr(ucg_pkg::OFS_CTRL_STATUS_C, 8'h00);
    wr(ucg_pkg::OFS_BAUD_HIGH, 8'hff);
    rd(ucg_pkg::OFS_BAUD_HIGH, v);
    chk("baud_divisor_high", v, 8'h0f);
    wr(ucg_pkg::OFS_BAUD_HIGH, 8'h01);
    wr(ucg_pkg::OFS_BAUD_LOW, 8'h02);
    rd(ucg_pkg::OFS_BAUD_LOW, v);
    chk("baud_divisor_low", v, 8'h02);
    period(0, p);
    chk("rxclk period 0x102", p, 259);
    wr(ucg_pkg::OFS_BAUD_HIGH, 8'h00);
    period(0, p);
    chk("rxclk period held high", p, 259);
    wr(ucg_pkg::OFS_BAUD_LOW, 8'h02);
    period(0, p);
    chk("rxclk period 2", p, 3);
    // Modes: normal, double, master, and master with the double-speed bit left set.
    for (int m = 0; m < 4; m++) begin
      wr(ucg_pkg::OFS_CTRL_STATUS_A, (m == 1 || m == 3) ? 8'h02 : 8'h00);
      wr(ucg_pkg::OFS_CTRL_STATUS_C, (m >= 2) ? 8'h40 : 8'h00);
      wr(ucg_pkg::OFS_XFER_DIR, (m >= 2) ? 8'h01 : 8'h00);
      rd(ucg_pkg::OFS_CLK_STATUS, v);
      chk("status mode", v[1:0], (m >= 2) ? 2 : m);
      period(1, p);
      chk("txclk period", p, (m == 0) ? 48 : (m == 1) ? 24 : 6);
      mx = 4'h0;
      repeat (60) begin
        @(negedge core_clk);
        if (rx_phase > mx) mx = rx_phase;
      end
      chk("last rx phase", mx, (m == 0) ? 4'hf : (m == 1) ? 4'h7 : 4'h1);
      chk("pin enable", xck_oe, m >= 2);
      if (m >= 2) begin
        period(2, p);
        chk("master pin rise period", p, 6);
        chk("master pin high at change", xck_out, 1'b1);
      end
    end
    wr(ucg_pkg::OFS_POWER_REDUCTION, 8'h01);
    // A tick launched at the write edge itself may still show, so counting starts one cycle later.
    @(posedge core_clk);
    c = 0;
    repeat (24) begin
      @(negedge core_clk);
      if (rxclk !== 1'b0 || xck_oe !== 1'b0) c++;
    end
    chk("activity under power cut", c, 0);
    rd(ucg_pkg::OFS_POWER_REDUCTION, v);
    chk("power_reduction_reg", v, 8'h01);
    wr(ucg_pkg::OFS_POWER_REDUCTION, 8'h00);
    period(0, p);
    chk("rxclk after power up", p, 3);
    wr(ucg_pkg::OFS_CTRL_STATUS_A, 8'h00);
    wr(ucg_pkg::OFS_XFER_DIR, 8'h00);
    for (int pol = 0; pol < 2; pol++) begin
      wr(ucg_pkg::OFS_CTRL_STATUS_C, pol[0] ? 8'h41 : 8'h40);
      rd(ucg_pkg::OFS_CLK_STATUS, v);
      chk("status slave", v[1:0], 2'h3);
      r0 = n_rise;
      f0 = n_fall;
      t0 = n_tx;
      c = n_rx;
      @(posedge core_clk);
      run <= 1'b1;
      if (pol == 0) begin
        p = 0;
        while (xck_in !== 1'b1 && p < 20) begin
          @(negedge core_clk);
          p++;
        end
        p = 0;
        while (tx_change !== 1'b1 && p < 20) begin
          @(negedge core_clk);
          p++;
        end
        chk("slave edge delay", p, 3);
      end
      repeat (48) @(posedge core_clk);
      run <= 1'b0;
      repeat (24) @(posedge core_clk);
      chk("slave pin edges seen", (n_rise - r0) > 0, 1'b1);
      chk("slave change pulses", n_tx - t0, pol ? n_fall - f0 : n_rise - r0);
      chk("slave sample pulses", n_rx - c, pol ? n_rise - r0 : n_fall - f0);
      chk("slave pin enable", xck_oe, 1'b0);
      chk("slave rx phase", rx_phase, 4'h0);
    end
    conclude();
  end
endmodule : usart_clock_generator_test
